// ---- core/ps_cfg_pkg.sv ----
// Shared constants, state codes and carrier types of the passive serial loader.
package ps_cfg_pkg;

    // Core clock period in nanoseconds (50 MHz).
    localparam int CLK_PERIOD_NS = 20;

    // Status low pulse width, least and longest, in microseconds.
    localparam int STATUS_MIN_US = 268;
    localparam int STATUS_MAX_US = 1506;
    // Request low to status and load-complete low, longest, in nanoseconds.
    localparam int REQ_RESP_MAX_NS = 600;
    // Load-complete high to user mode on the internal oscillator, in microseconds.
    localparam int INIT_OSC_MIN_US = 175;
    localparam int INIT_OSC_MAX_US = 437;
    // Longest serial clock period in nanoseconds and the count of them before the user clock.
    localparam int SLC_PERIOD_MAX_NS = 8;
    localparam int USR_ENABLE_PERIODS = 4;
    // User clock periods from user clock enable to user mode.
    localparam int USR_INIT_PERIODS = 17408;

    // Derived cycle counts: least times round up, longest times round down.
    localparam int STATUS_MIN_CYC = (STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STATUS_MAX_CYC = (STATUS_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int REQ_RESP_MAX_CYC = REQ_RESP_MAX_NS / CLK_PERIOD_NS;
    localparam int INIT_OSC_MIN_CYC = (INIT_OSC_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_OSC_MAX_CYC = (INIT_OSC_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int USR_ENABLE_CYC =
        (USR_ENABLE_PERIODS * SLC_PERIOD_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Width of the long cycle counters.
    localparam int CNT_W = 17;
    // Width of one configuration word assembled from serial bits.
    localparam int WORD_W = 8;
    // Depth of the word buffer.
    localparam int FIFO_DEPTH = 8;
    // Width of the link-side bit counters.
    localparam int BIT_CNT_W = 24;
    // Extra falling serial clock edges that start initialization.
    localparam int INIT_FALL_EDGES = 2;

    // Sequencer states, one-hot.
    typedef enum logic [6:0] {
        ST_POR = 7'h01,
        ST_RESET = 7'h02,
        ST_HOLD = 7'h04,
        ST_LOAD = 7'h08,
        ST_START = 7'h10,
        ST_INIT = 7'h20,
        ST_USER = 7'h40
    } cfg_state_t;

    // One word handed from the link domain, with its event toggle.
    typedef struct packed {
        logic tgl;
        logic [WORD_W-1:0] data;
    } word_xfer_t;

endpackage

// ---- core/cfg_word_fifo.sv ----
// Word buffer between the serial receiver and the configuration memory sink.
`timescale 1ns/1ps
module cfg_word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_clear,
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [WIDTH-1:0] o_rd_data
);
    localparam int AW = $clog2(DEPTH);

    // Storage words and pointers; count holds the fill level.
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire logic do_wr;
    wire logic do_rd;

    // Full and empty follow the fill level directly.
    assign o_wr_ready = (count_reg != (AW + 1)'(DEPTH));
    assign o_rd_valid = (count_reg != '0);
    assign o_rd_data = mem_reg[rd_ptr_reg];
    assign do_wr = i_wr_valid && o_wr_ready;
    assign do_rd = o_rd_valid && i_rd_ready;

    // Pointer and level update; a clear empties the buffer for a new load.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (i_clear) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
        end
    end

    // Storage write; no reset is needed on the data words.
    always_ff @(posedge i_clk) begin
        if (do_wr) begin
            mem_reg[wr_ptr_reg] <= i_wr_data;
        end
    end
endmodule

// ---- core/passive_serial_config_load.sv ----
// Passive serial configuration sequencer with serial receiver and word buffer.
// Behaviour
// - User mode: request and complete high; status high unless the buffer overflowed.
// - Request fall drives complete low within 600ns.
// - Request fall drives status low within 600ns.
// - Status low between 268us and 1506us.
// - Status released within 1506us after request rises.
// - Status held low for power-on delay.
// - Complete low from power-up through loading.
// - Data captured on rising serial clock edges.
// - Complete after full stream; two falls start.
// - Oscillator init reaches user mode in 175-437us.
// - User clock: 4 periods, then 17408 cycles.
// - Init clock: oscillator or user clock, limits.
// - Init-done output low until initialization finishes.
// - Data pin becomes user input after configuration.
`timescale 1ns/1ps
module passive_serial_config_load
    import ps_cfg_pkg::*;
#(
    parameter int BITSTREAM_WORDS = 16,
    parameter int POR_CYC = ps_cfg_pkg::STATUS_MIN_CYC,
    parameter int STATUS_MIN_CYC_P = ps_cfg_pkg::STATUS_MIN_CYC,
    parameter int INIT_OSC_CYC_P = ps_cfg_pkg::INIT_OSC_MIN_CYC,
    parameter int USR_INIT_PERIODS_P = ps_cfg_pkg::USR_INIT_PERIODS
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_serial_load_clock,
    input wire logic i_serial_load_data,
    input wire logic i_cfg_request_n,
    input wire logic i_cfg_health_n,
    output logic o_cfg_health_n,
    output logic o_cfg_health_n_oe,
    input wire logic i_load_complete,
    output logic o_load_complete,
    output logic o_load_complete_oe,
    input wire logic i_user_init_clock,
    input wire logic i_user_clk_opt,
    input wire logic i_init_done_opt,
    output logic o_init_done_n,
    output logic o_user_mode,
    output logic o_user_io,
    output logic o_overflow,
    output logic [ps_cfg_pkg::WORD_W-1:0] o_cfg_word,
    output logic o_cfg_valid,
    input wire logic i_cfg_ready
);
    import ps_cfg_pkg::*;

    // Total serial bits of one bitstream and the falling edges that start initialization.
    localparam logic [BIT_CNT_W-1:0] TOTAL_BITS = BIT_CNT_W'(BITSTREAM_WORDS * WORD_W);
    localparam logic [BIT_CNT_W-1:0] START_FALLS = BIT_CNT_W'(BITSTREAM_WORDS * WORD_W
        + INIT_FALL_EDGES);
    localparam int BIT_IDX_W = $clog2(WORD_W);
    localparam int WORD_CNT_W = $clog2(BITSTREAM_WORDS + 1);

    // Two-flop synchronisers for pins and link-domain levels.
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    wire logic req_n_s;
    wire logic health_pin_s;
    wire logic data_pin_s;
    wire logic usr_clk_s;
    wire logic start_s;
    wire logic word_tgl_s;

    // Sequencer state, counters and registered pin controls.
    cfg_state_t state_reg;
    cfg_state_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [WORD_CNT_W-1:0] word_cnt_reg;
    logic word_tgl_d_reg;
    logic usr_clk_d_reg;
    logic health_oe_reg;
    logic done_oe_reg;
    logic init_done_n_reg;
    logic user_io_reg;
    logic overflow_reg;
    logic link_en_reg;

    // Link-domain registers; the link logic is held reset outside the load and start states.
    wire logic link_rst_n;
    logic [BIT_IDX_W-1:0] bit_idx_reg;
    logic [WORD_W-1:0] shift_reg;
    logic [BIT_CNT_W-1:0] rise_cnt_reg;
    logic [BIT_CNT_W-1:0] fall_cnt_reg;
    logic start_link_reg;
    word_xfer_t xfer_reg;

    // Buffer fill side and sequencer condition decodes.
    wire logic word_arrive;
    wire logic fifo_wr_ready;
    wire logic stream_done;
    wire logic usr_rise;
    wire logic init_target;
    wire logic status_ok;

    assign {word_tgl_s, start_s, usr_clk_s, data_pin_s, health_pin_s, req_n_s} = sync2_reg;
    assign link_rst_n = i_nrst && link_en_reg;

    // Synchronisers, second stage read only; event bits reset low to avoid a false edge.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1_reg <= 6'h07;
            sync2_reg <= 6'h07;
        end else begin
            sync1_reg <= {xfer_reg.tgl, start_link_reg, i_user_init_clock,
                          i_serial_load_data, i_cfg_health_n, i_cfg_request_n};
            sync2_reg <= sync1_reg;
        end
    end

    // rising edge capture: serial bits are shifted in on rising link clock edges.
    always_ff @(posedge i_serial_load_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_idx_reg <= '0;
            shift_reg <= '0;
            rise_cnt_reg <= '0;
            xfer_reg <= '0;
        end else if (rise_cnt_reg != TOTAL_BITS) begin
            shift_reg <= {shift_reg[WORD_W-2:0], i_serial_load_data};
            rise_cnt_reg <= rise_cnt_reg + 1'b1;
            bit_idx_reg <= (bit_idx_reg == BIT_IDX_W'(WORD_W - 1)) ? '0 : bit_idx_reg + 1'b1;
            // A full word is posted with a toggle so the core sees one event.
            if (bit_idx_reg == BIT_IDX_W'(WORD_W - 1)) begin
                xfer_reg.data <= {shift_reg[WORD_W-2:0], i_serial_load_data};
                xfer_reg.tgl <= ~xfer_reg.tgl;
            end
        end
    end

    // extra falls: count falling edges until the stream plus two more have passed.
    always_ff @(negedge i_serial_load_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            fall_cnt_reg <= '0;
            start_link_reg <= 1'b0;
        end else if (fall_cnt_reg != START_FALLS) begin
            fall_cnt_reg <= fall_cnt_reg + 1'b1;
            start_link_reg <= (fall_cnt_reg == START_FALLS - 1'b1);
        end
    end

    // Word arrival, stream end and user clock edge decode.
    assign word_arrive = (word_tgl_s != word_tgl_d_reg) && (state_reg == ST_LOAD);
    assign stream_done = (word_cnt_reg == WORD_CNT_W'(BITSTREAM_WORDS));
    assign usr_rise = usr_clk_s && !usr_clk_d_reg;
    assign status_ok = (cnt_reg >= CNT_W'(STATUS_MIN_CYC_P));
    // init clock: oscillator cycle count or sampled user clock periods.
    assign init_target = i_user_clk_opt ?
        (cnt_reg == CNT_W'(USR_ENABLE_CYC + USR_INIT_PERIODS_P)) :
        (cnt_reg == CNT_W'(INIT_OSC_CYC_P));

    // Next state and counter.
    always_comb begin
        state_next = state_reg;
        cnt_next = (cnt_reg == '1) ? cnt_reg : cnt_reg + 1'b1;
        unique case (state_reg)
            // power-on: status stays low for the power-on delay.
            ST_POR: begin
                if (cnt_reg >= CNT_W'(POR_CYC)) begin
                    state_next = ST_HOLD;
                end
            end
            // status pulse: low while requested and for the least width.
            ST_RESET: begin
                if (req_n_s && status_ok) begin
                    state_next = ST_HOLD;
                end
            end
            // release: loading waits while another party holds status low.
            ST_HOLD: begin
                if (health_pin_s) begin
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (stream_done) begin
                    state_next = ST_START;
                end
            end
            ST_START: begin
                cnt_next = '0;
                if (start_s) begin
                    state_next = ST_INIT;
                end
            end
            // user clock: wait the enable delay, then count user clock rises.
            ST_INIT: begin
                if (i_user_clk_opt && cnt_reg >= CNT_W'(USR_ENABLE_CYC)) begin
                    cnt_next = usr_rise ? cnt_reg + 1'b1 : cnt_reg;
                end
                if (init_target) begin
                    state_next = ST_USER;
                end
            end
            ST_USER: begin
                cnt_next = '0;
            end
            default: begin
                state_next = ST_POR;
            end
        endcase
        // new cycle: a low request restarts from any state but power-on.
        if (!req_n_s && state_reg != ST_POR) begin
            state_next = ST_RESET;
        end
        if (state_next != state_reg) begin
            cnt_next = '0;
        end
    end

    // State, counter and word bookkeeping.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= ST_POR;
            cnt_reg <= '0;
            word_cnt_reg <= '0;
            word_tgl_d_reg <= 1'b0;
            usr_clk_d_reg <= 1'b0;
            overflow_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            usr_clk_d_reg <= usr_clk_s;
            word_tgl_d_reg <= link_en_reg ? word_tgl_s : 1'b0;
            if (state_reg == ST_RESET) begin
                word_cnt_reg <= '0;
            end else if (word_arrive) begin
                word_cnt_reg <= word_cnt_reg + 1'b1;
            end
            // A word that finds the buffer full is dropped and flagged until the next cycle.
            if (state_reg == ST_RESET) begin
                overflow_reg <= 1'b0;
            end else if (word_arrive && !fifo_wr_ready) begin
                overflow_reg <= 1'b1;
            end
        end
    end

    // Registered pin drives derived from the next state.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            health_oe_reg <= 1'b1;
            done_oe_reg <= 1'b1;
            init_done_n_reg <= 1'b1;
            user_io_reg <= 1'b0;
            link_en_reg <= 1'b0;
        end else begin
            // status low: driven while resetting or on an overflow.
            health_oe_reg <= (state_next == ST_POR) || (state_next == ST_RESET) || overflow_reg;
            // complete low: driven from the first cycle of a request.
            // complete low through power-up and loading.
            done_oe_reg <= (state_next == ST_POR) || (state_next == ST_RESET) ||
                           (state_next == ST_HOLD) || (state_next == ST_LOAD);
            // init done: low from the end of loading until user mode.
            init_done_n_reg <= !(i_init_done_opt &&
                                 (state_next == ST_START || state_next == ST_INIT));
            // user input: the data pin reaches user logic in user mode only.
            user_io_reg <= (state_next == ST_USER) ? data_pin_s : 1'b0;
            link_en_reg <= (state_next == ST_LOAD) || (state_next == ST_START);
        end
    end

    // Buffer between the receiver and the configuration memory sink.
    cfg_word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_clear(state_reg == ST_RESET),
        .i_wr_valid(word_arrive),
        .o_wr_ready(fifo_wr_ready),
        .i_wr_data(xfer_reg.data),
        .o_rd_valid(o_cfg_valid),
        .i_rd_ready(i_cfg_ready),
        .o_rd_data(o_cfg_word)
    );

    // Open-drain pins drive low only; the enable decides.
    assign o_cfg_health_n = 1'b0;
    assign o_cfg_health_n_oe = health_oe_reg;
    assign o_load_complete = 1'b0;
    assign o_load_complete_oe = done_oe_reg;
    assign o_init_done_n = init_done_n_reg;
    assign o_user_mode = (state_reg == ST_USER);
    assign o_user_io = user_io_reg;
    assign o_overflow = overflow_reg;

    // Helper counters for the checks below.
    localparam int RESP_MAX = REQ_RESP_MAX_CYC;
    logic [CNT_W-1:0] low_cnt_reg;
    logic [CNT_W-1:0] rel_cnt_reg;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            low_cnt_reg <= '0;
            rel_cnt_reg <= '0;
        end else begin
            low_cnt_reg <= health_oe_reg ? low_cnt_reg + 1'b1 : '0;
            rel_cnt_reg <= (req_n_s && health_oe_reg) ? rel_cnt_reg + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_req_status_low: assert property ($fell(req_n_s) && state_reg != ST_POR |->
        ##[1:RESP_MAX] o_cfg_health_n_oe) else $error("status not low after request");
    a_req_done_low: assert property ($fell(req_n_s) |-> ##[1:RESP_MAX] o_load_complete_oe)
        else $error("complete not low after request");
    a_status_min: assert property ($fell(health_oe_reg) && $past(state_reg) == ST_RESET |->
        $past(low_cnt_reg) >= CNT_W'(STATUS_MIN_CYC_P)) else $error("status pulse too short");
    a_status_release: assert property (rel_cnt_reg <= CNT_W'(STATUS_MAX_CYC))
        else $error("status held too long after request rose");
    a_por_hold: assert property (state_reg == ST_POR |-> o_cfg_health_n_oe)
        else $error("status released during power-on");
    a_done_load: assert property (state_reg == ST_LOAD |-> o_load_complete_oe)
        else $error("complete released during load");
    a_done_words: assert property ($fell(done_oe_reg) |-> word_cnt_reg ==
        WORD_CNT_W'(BITSTREAM_WORDS)) else $error("complete released early");
    a_osc_init: assert property ($rose(o_user_mode) && !i_user_clk_opt |->
        $past(cnt_reg) == CNT_W'(INIT_OSC_CYC_P)) else $error("oscillator init time wrong");
    a_usr_init: assert property ($rose(o_user_mode) && i_user_clk_opt |->
        $past(cnt_reg) == CNT_W'(USR_ENABLE_CYC + USR_INIT_PERIODS_P))
        else $error("user clock init count wrong");
    a_user_pins: assert property (o_user_mode |->
        !o_cfg_health_n_oe && !o_load_complete_oe && o_init_done_n)
        else $error("pins not released in user mode");
    a_init_done: assert property (state_reg == ST_INIT && $past(state_reg) == ST_INIT &&
        i_init_done_opt && $past(i_init_done_opt) |-> !o_init_done_n)
        else $error("init done not low during init");
    a_user_io: assert property (!o_user_mode && $past(state_reg) != ST_USER |->
        !o_user_io) else $error("user input active before user mode");
endmodule

// ---- dv/cfg_host_model.sv ----
// Behavioural configuration host that clocks serial bits into the loader.
`timescale 1ns/1ps
module cfg_host_model (
    output logic o_serial_load_clock,
    output logic o_serial_load_data
);
    // Half of the 64 ns serial clock period.
    localparam int HALF_NS = 32;
    initial begin
        o_serial_load_clock = 1'b0;
        o_serial_load_data = 1'b0;
    end
    // Sends one word, first bit ends in bit 7.
    task automatic send_word(input logic [7:0] w);
        #(7);
        for (int i = 7; i >= 0; i--) begin
            o_serial_load_data = w[i];
            #(HALF_NS);
            o_serial_load_clock = 1'b1;
            #(HALF_NS);
            o_serial_load_clock = 1'b0;
        end
        // A released line shows the inverse of the last bit.
        o_serial_load_data = ~w[0];
    endtask
    task automatic send_falls(input int n);
        for (int i = 0; i < n; i++) begin
            #(HALF_NS);
            o_serial_load_clock = 1'b1;
            #(HALF_NS);
            o_serial_load_clock = 1'b0;
        end
    endtask
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the passive serial loader and its word buffer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin fails++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
    import ps_cfg_pkg::*;
    localparam int WORDS = FIFO_DEPTH;
    localparam int STAT_P = 200;
    localparam int OSC_P = 40;
    localparam int USR_P = 10;
    logic i_clk, i_nrst, req_n, usr_clk, usr_opt, ready, hold, done_opt;
    logic slc, sld, health_oe, complete_oe, init_done_n, user_mode, user_io, overflow, valid;
    logic [WORD_W-1:0] word;
    // Open-drain wires: high unless the device pulls them down.
    wire health_w = !health_oe;
    wire complete_w = !complete_oe;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    int t0;
    logic [WORD_W-1:0] expq[$];
    cfg_host_model host_u (.o_serial_load_clock(slc), .o_serial_load_data(sld));
    passive_serial_config_load #(.BITSTREAM_WORDS(WORDS), .POR_CYC(20), .STATUS_MIN_CYC_P(STAT_P),
        .INIT_OSC_CYC_P(OSC_P), .USR_INIT_PERIODS_P(USR_P)) dut_u (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_serial_load_clock(slc), .i_serial_load_data(sld),
        .i_cfg_request_n(req_n), .i_cfg_health_n(health_w), .o_cfg_health_n(),
        .o_cfg_health_n_oe(health_oe), .i_load_complete(complete_w), .o_load_complete(),
        .o_load_complete_oe(complete_oe), .i_user_init_clock(usr_clk), .i_user_clk_opt(usr_opt),
        .i_init_done_opt(done_opt), .o_init_done_n(init_done_n), .o_user_mode(user_mode),
        .o_user_io(user_io), .o_overflow(overflow), .o_cfg_word(word), .o_cfg_valid(valid),
        .i_cfg_ready(ready));
    // Core clock of 20 ns and a free user clock of 200 ns.
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    initial begin
        usr_clk = 1'b0;
        forever #100 usr_clk = ~usr_clk;
    end
    // Stalling sink compares each accepted word with the model queue.
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (i_nrst) begin
            ready <= hold ? 1'b0 : 1'($urandom_range(0, 1));
        end
        if (valid === 1'b1 && ready === 1'b1) begin
            if (expq.size() > 0) begin
                `CHK("cfg word", expq.pop_front(), word)
            end else begin
                `CHK("extra word", 0, 1)
            end
        end
    end
    task automatic end_sim();
        if (fails == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Waits a bounded number of cycles for a design output to reach a level.
    task automatic wait_for(input string nm, ref logic sig, input logic val, input int lim,
        output int cnt);
        cnt = 0;
        while (sig !== val) begin
            @(posedge i_clk);
            cnt++;
            if (cnt > lim) begin
                fails++;
                $display("CHECK FAILED %s exp %0h got %0h", nm, val, sig);
                end_sim();
            end
        end
    endtask
    // One full reconfiguration, initialized by the oscillator or the user clock.
    task automatic configure(input logic opt);
        logic [WORD_W-1:0] w;
        @(posedge i_clk);
        usr_opt <= opt;
        done_opt <= ~opt;
        hold <= !opt;
        req_n <= 1'b0;
        wait_for("status low", health_oe, 1'b1, 30, n);
        `CHK("complete low", 1'b1, complete_oe)
        `CHK("status low time", 1'b1, n <= 30)
        repeat (100) @(posedge i_clk);
        req_n <= 1'b1;
        wait_for("status release", health_oe, 1'b0, 75300, n);
        `CHK("status min width", 1'b1, n >= 90 && n <= 110)
        `CHK("status release", 1'b1, health_w)
        repeat (100) @(posedge i_clk);
        for (int k = 0; k < WORDS; k++) begin
            w = WORD_W'($urandom);
            expq.push_back(w);
            `CHK("complete held", 1'b1, complete_oe)
            host_u.send_word(w);
        end
        wait_for("complete release", complete_oe, 1'b0, 20, n);
        // A stalled sink leaves the whole stream in the buffer, which is then exactly full.
        if (!opt) begin
            `CHK("buffer held", 1'b1, valid)
            `CHK("buffer full", 1'b0, dut_u.fifo_wr_ready)
            `CHK("buffer head", expq[0], word)
            `CHK("buffer no drop", 1'b0, overflow)
        end
        hold <= 1'b0;
        t0 = cyc;
        repeat (3) @(posedge i_clk);
        `CHK("init done low", ~done_opt, init_done_n)
        `CHK("no user mode", 1'b0, user_mode)
        host_u.send_falls(INIT_FALL_EDGES);
        wait_for("user mode", user_mode, 1'b1, 400, n);
        n = cyc - t0;
        if (opt) begin
            `CHK("user clock init", 1'b1, n >= USR_P * 10 && n <= USR_P * 10 + 40)
        end else begin
            `CHK("oscillator init", 1'b1, n >= OSC_P && n <= OSC_P + 25)
        end
        `CHK("init clock choice", 1'b1, opt ? n > OSC_P + 25 : n < USR_P * 10)
        repeat (4) @(posedge i_clk);
        `CHK("init done high", 1'b1, init_done_n)
        `CHK("user status", 1'b1, health_w)
        `CHK("user complete", 1'b1, complete_w)
        `CHK("user io", sld, user_io)
        `CHK("words left", 0, expq.size())
        `CHK("buffer empty", 1'b0, valid)
        `CHK("no overflow", 1'b0, overflow)
    endtask
    initial begin
        i_nrst = 1'b0;
        req_n = 1'b1;
        usr_opt = 1'b0;
        ready = 1'b0;
        hold = 1'b0;
        done_opt = 1'b1;
        void'($urandom(14890));
        repeat (4) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        `CHK("por status", 1'b1, health_oe)
        `CHK("por complete", 1'b1, complete_oe)
        wait_for("por release", health_oe, 1'b0, 40, n);
        `CHK("por length", 1'b1, n >= 17)
        configure(1'b0);
        configure(1'b1);
        end_sim();
    end
endmodule
